/* include/region_pkg.sv */
// Package: region map constants and encodings for the physical address decoder
`default_nettype none
package region_pkg;

  localparam int ADDR_W = 34;
  localparam int PCI_ADDR_W = 32;
  localparam int SPARSE_SHIFT = 5;
  localparam int LOCK_BLOCK_LSB = 5;

  // Region base addresses (inclusive lower bounds)
  localparam logic [33:0] BASE_NONCACHE = 34'h0_2000_0000;
  localparam logic [33:0] BASE_NXM = 34'h0_4000_0000;
  localparam logic [33:0] BASE_GFX = 34'h1_0000_0000;
  localparam logic [33:0] BASE_MC_REG = 34'h1_2000_0000;
  localparam logic [33:0] BASE_PIO_REG = 34'h1_8000_0000;
  localparam logic [33:0] BASE_PCI_IACK = 34'h1_a000_0000;
  localparam logic [33:0] BASE_PCI_IO = 34'h1_c000_0000;
  localparam logic [33:0] BASE_PCI_CFG = 34'h1_e000_0000;
  localparam logic [33:0] BASE_PCI_SPARSE = 34'h2_0000_0000;
  localparam logic [33:0] BASE_PCI_DENSE = 34'h3_0000_0000;

  localparam logic [1:0] QUAD_LOW = 2'h0;
  localparam logic [33:0] RESV_ADDR_RST = 34'h0_0000_0000;
  localparam logic RESV_VALID_RST = 1'b0;

  typedef enum logic [3:0] {
    REG_CACHEABLE,
    REG_NONCACHE,
    REG_NXM,
    REG_GFX,
    REG_MC_REG,
    REG_PIO_REG,
    REG_PCI_IACK,
    REG_PCI_IO,
    REG_PCI_CFG,
    REG_PCI_SPARSE,
    REG_PCI_DENSE
  } region_e;

endpackage
`default_nettype wire

/* core/phys_addr_region_decoder.sv */
// Physical address region decoder with load-locked reservation monitor
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE1: Every address is 34 bits and falls in exactly one fixed region.
// RULE2: Only 0_0000_0000..0_1FFF_FFFF is cacheable and updates the board cache.
// RULE3: 0_2000_0000.. is noncacheable memory; 0_4000_0000..0_FFFF_FFFF is nonexistent.
// RULE4: 1_0000_0000..1_1FFF_FFFF is graphics; graphics writes only apply there.
// RULE5: 1_2000_0000.. selects memory-controller regs; 1_8000_0000.. I/O controller regs.
// RULE6: 1_A/1_C/1_E blocks select PCI ack/special, PCI I/O, PCI config.
// RULE7: Sparse region 2_xxxx_xxxx shifts the address right by five bits.
// RULE8: Dense region 3_xxxx_xxxx passes the address unshifted.
// RULE9: Fetches with address bits 33:32 nonzero are refused.
// RULE10: Low-quadrant fetches fill instruction cache, never allocate board cache; the code raises fill only below 0_4000_0000.
// RULE11: Inbound 32-bit bus-master addresses only reach the two memory regions.
// RULE12: Memory side serves memory and its regs; I/O controller gets its targets.
// RULE13: Keep a reservation flag and a 32-byte aligned reservation address.
// RULE14: Store-conditional, DMA hit, exception return or controller lock clear the flag.
// RULE15: Load-locked does not set the flag while the I/O controller is locked.
// RULE16: Region select and attributes come combinationally from the request address.
module phys_addr_region_decoder (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [33:0] REQ_ADDR,
  input wire logic REQ_FETCH,
  input wire logic REQ_WRITE,
  input wire logic [31:0] DMA_ADDR,
  input wire logic [33:0] DMA_XLATE_ADDR,
  input wire logic DMA_WRITE,
  input wire logic LOAD_LOCKED,
  input wire logic STORE_CONDITIONAL,
  input wire logic EXCEPTION_RETURN_CALL,
  input wire logic PIO_LOCKED,
  output var region_pkg::region_e REGION,
  output logic CACHEABLE,
  output logic BCACHE_ALLOC,
  output logic ICACHE_FILL,
  output logic GFX_WRITE,
  output logic FETCH_REFUSED,
  output logic TO_MEM_CTRL,
  output logic TO_PERIPHERAL_IO,
  output logic [33:0] BUS_ADDR,
  output logic DMA_REFUSED,
  output logic RESV_VALID,
  output logic [33:0] RESV_ADDR
);

  // DMA_ADDR is the raw inbound address; only the translated one is judged.
  typedef struct packed {
    logic valid;
    logic [33:0] addr;
    logic lock_d;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // ------------------------------------------------------------
  // Region classification
  // ------------------------------------------------------------
  function automatic region_pkg::region_e classify(input logic [33:0] a);
    region_pkg::region_e r;
    r = region_pkg::REG_CACHEABLE;
    if (a >= region_pkg::BASE_PCI_DENSE) r = region_pkg::REG_PCI_DENSE;
    else if (a >= region_pkg::BASE_PCI_SPARSE) r = region_pkg::REG_PCI_SPARSE;
    else if (a >= region_pkg::BASE_PCI_CFG) r = region_pkg::REG_PCI_CFG;
    else if (a >= region_pkg::BASE_PCI_IO) r = region_pkg::REG_PCI_IO;
    else if (a >= region_pkg::BASE_PCI_IACK) r = region_pkg::REG_PCI_IACK;
    else if (a >= region_pkg::BASE_PIO_REG) r = region_pkg::REG_PIO_REG;
    else if (a >= region_pkg::BASE_MC_REG) r = region_pkg::REG_MC_REG;
    else if (a >= region_pkg::BASE_GFX) r = region_pkg::REG_GFX;
    else if (a >= region_pkg::BASE_NXM) r = region_pkg::REG_NXM;
    else if (a >= region_pkg::BASE_NONCACHE) r = region_pkg::REG_NONCACHE;
    return r;
  endfunction

  region_pkg::region_e cpu_reg;
  region_pkg::region_e dma_reg;
  logic upper_quad;
  logic mem_side;

  // Decode is purely combinational so attributes track the address same cycle
  always_comb begin
    cpu_reg = classify(REQ_ADDR); // [RULE1] [RULE3] [RULE5] [RULE6] [RULE16]
    dma_reg = classify(DMA_XLATE_ADDR);
    upper_quad = (REQ_ADDR[33:32] != region_pkg::QUAD_LOW); // [RULE9]
    REGION = cpu_reg;
    CACHEABLE = (cpu_reg == region_pkg::REG_CACHEABLE); // [RULE2]
    FETCH_REFUSED = REQ_FETCH && upper_quad; // [RULE9]
    ICACHE_FILL = REQ_FETCH && !upper_quad && (cpu_reg == region_pkg::REG_CACHEABLE
                  || cpu_reg == region_pkg::REG_NONCACHE); // [RULE10]
    BCACHE_ALLOC = CACHEABLE && !REQ_FETCH; // [RULE2] [RULE10]
    GFX_WRITE = REQ_WRITE && (cpu_reg == region_pkg::REG_GFX); // [RULE4]
    // Refused fetches go to neither side, so no cycle is spent on them
    mem_side = (cpu_reg == region_pkg::REG_CACHEABLE) || (cpu_reg == region_pkg::REG_NONCACHE)
               || (cpu_reg == region_pkg::REG_NXM) || (cpu_reg == region_pkg::REG_GFX)
               || (cpu_reg == region_pkg::REG_MC_REG); // [RULE12]
    TO_MEM_CTRL = mem_side && !FETCH_REFUSED; // [RULE9] [RULE12]
    TO_PERIPHERAL_IO = !mem_side && !FETCH_REFUSED; // [RULE12]
    if (cpu_reg == region_pkg::REG_PCI_SPARSE) begin
      BUS_ADDR = REQ_ADDR >> region_pkg::SPARSE_SHIFT; // [RULE7]
    end else begin
      BUS_ADDR = REQ_ADDR; // [RULE8]
    end
    // Translated bus-master address must land in low memory only
    DMA_REFUSED = !(dma_reg == region_pkg::REG_CACHEABLE
                    || dma_reg == region_pkg::REG_NONCACHE); // [RULE11]
  end

  // ------------------------------------------------------------
  // Reservation monitor
  // ------------------------------------------------------------
  logic dma_hit;
  always_comb begin
    st_nxt = st_r;
    st_nxt.lock_d = PIO_LOCKED;
    dma_hit = DMA_WRITE && st_r.valid && !DMA_REFUSED
              && (DMA_XLATE_ADDR[33:region_pkg::LOCK_BLOCK_LSB]
                  == st_r.addr[33:region_pkg::LOCK_BLOCK_LSB]);
    if (LOAD_LOCKED && !PIO_LOCKED) begin // [RULE15]
      st_nxt.valid = 1'b1; // [RULE13]
      st_nxt.addr = {REQ_ADDR[33:region_pkg::LOCK_BLOCK_LSB],
                     {region_pkg::LOCK_BLOCK_LSB{1'b0}}};
    end
    // Clears win: a lost reservation only makes a retry, never a false success
    if (STORE_CONDITIONAL || dma_hit || EXCEPTION_RETURN_CALL
        || (PIO_LOCKED && !st_r.lock_d)) begin
      st_nxt.valid = 1'b0; // [RULE14]
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_r <= '{valid: region_pkg::RESV_VALID_RST, addr: region_pkg::RESV_ADDR_RST, lock_d: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RESV_VALID = st_r.valid;
  assign RESV_ADDR = st_r.addr;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Reservation clear events seen from the outputs
  sequence s_dma_hit;
    DMA_WRITE && !DMA_REFUSED && RESV_VALID
      && DMA_XLATE_ADDR[33:5] == RESV_ADDR[33:5];
  endsequence
  sequence s_lock_enter;
    PIO_LOCKED && !$past(PIO_LOCKED);
  endsequence
  a_fetch_refuse: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE9]
    REQ_FETCH && REQ_ADDR[33:32] != 2'h0 |-> FETCH_REFUSED && !ICACHE_FILL)
    else $error("upper quadrant fetch not refused");
  a_cache_only_low: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE2]
    CACHEABLE == (REQ_ADDR < region_pkg::BASE_NONCACHE))
    else $error("cacheable range wrong");
  a_fetch_no_bcache: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE10]
    REQ_FETCH |-> !BCACHE_ALLOC)
    else $error("fetch allocated board cache");
  a_gfx_only: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE4]
    GFX_WRITE |-> REQ_ADDR[33:29] == 5'h08)
    else $error("graphics write outside region");
  a_sparse_shift: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE7]
    REQ_ADDR[33:32] == 2'h2 |-> BUS_ADDR == {5'h00, REQ_ADDR[33:5]})
    else $error("sparse shift wrong");
  a_dense_pass: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE8]
    REQ_ADDR[33:32] == 2'h3 |-> BUS_ADDR == REQ_ADDR)
    else $error("dense address altered");
  a_dma_window: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE11]
    DMA_XLATE_ADDR >= region_pkg::BASE_NXM |-> DMA_REFUSED)
    else $error("bus master reached forbidden region");
  a_route_one: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE12]
    !(TO_MEM_CTRL && TO_PERIPHERAL_IO))
    else $error("request routed to both sides");
  a_sc_clears: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE14]
    STORE_CONDITIONAL || EXCEPTION_RETURN_CALL |=> !RESV_VALID)
    else $error("reservation survived clear");
  a_locked_no_set: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE15]
    !RESV_VALID && PIO_LOCKED ##0 LOAD_LOCKED |=> !RESV_VALID)
    else $error("reservation set while locked");
  a_ll_sets: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE13]
    LOAD_LOCKED && !PIO_LOCKED && !STORE_CONDITIONAL && !EXCEPTION_RETURN_CALL
    && !DMA_WRITE |=> RESV_VALID && RESV_ADDR[4:0] == 5'h00
    && RESV_ADDR[33:5] == $past(REQ_ADDR[33:5]))
    else $error("reservation not taken");
  a_dma_hit_clear: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE14]
    s_dma_hit |=> !RESV_VALID)
    else $error("reservation survived bus master write");
  a_lock_clear: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE14]
    s_lock_enter |=> !RESV_VALID)
    else $error("reservation survived controller lock");
  a_refused_unrouted: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE9]
    FETCH_REFUSED |-> !TO_MEM_CTRL && !TO_PERIPHERAL_IO)
    else $error("refused fetch was routed");
  a_route_some: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE12]
    !FETCH_REFUSED |-> TO_MEM_CTRL || TO_PERIPHERAL_IO)
    else $error("request routed nowhere");
  a_pio_to_io: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE12]
    REQ_ADDR[33:29] == 5'h0c && !REQ_FETCH |-> TO_PERIPHERAL_IO && !TO_MEM_CTRL)
    else $error("controller register access not handed over");
  a_icache_low: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE10]
    ICACHE_FILL |-> REQ_FETCH && REQ_ADDR < region_pkg::BASE_NXM)
    else $error("instruction fill outside low memory");
  a_nxm_region: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE3]
    REQ_ADDR[33:32] == 2'h0 && REQ_ADDR[31:30] != 2'h0 |-> REGION == region_pkg::REG_NXM)
    else $error("nonexistent memory not decoded");
  a_gfx_write_on: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE4]
    REQ_WRITE && REQ_ADDR[33:29] == 5'h08 |-> GFX_WRITE)
    else $error("graphics write not flagged");
  a_resv_aligned: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE13]
    RESV_ADDR[4:0] == 5'h00)
    else $error("reservation address not aligned");
  a_resv_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE13]
    !LOAD_LOCKED |=> RESV_ADDR == $past(RESV_ADDR))
    else $error("reservation address moved");
  a_dma_allowed: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE11]
    DMA_XLATE_ADDR < region_pkg::BASE_NXM |-> !DMA_REFUSED)
    else $error("bus master refused in low memory");

endmodule
`default_nettype wire

/* bench/dma_path_model.sv */
// Bus-master path model: hands translated write addresses to the decoder
`timescale 1ns/10ps
`default_nettype none
module dma_path_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [31:0] pci_addr,
  output logic [33:0] xlate,
  output logic wr
);
  // Idle cycles invert the address so a stale value never looks held
  always_ff @(posedge clk) begin
    wr <= req;
    xlate <= req ? {2'h0, pci_addr} : ~xlate;
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Testbench for the physical address region decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module testbench;
  logic clk = 0, rst = 1, fetch = 0, wr = 0, ll = 0, sc = 0, erc = 0, plock = 0, dreq = 0;
  logic [33:0] addr = '0, xl, rbus, raddr;
  logic [31:0] daddr = '0;
  logic dwr, cach, balloc, ifill, gfx, frefd, tomem, toio, drefd, rvalid;
  region_pkg::region_e region;
  int failures = 0, checks = 0;
  logic [33:0] base [11];
  initial forever #25 clk = ~clk;
  dma_path_model i_dma (.clk(clk), .req(dreq), .pci_addr(daddr), .xlate(xl), .wr(dwr));
  phys_addr_region_decoder i_dut (.SYS_CLK(clk), .RST(rst), .REQ_ADDR(addr), .REQ_FETCH(fetch),
    .REQ_WRITE(wr), .DMA_ADDR(daddr), .DMA_XLATE_ADDR(xl), .DMA_WRITE(dwr), .LOAD_LOCKED(ll),
    .STORE_CONDITIONAL(sc), .EXCEPTION_RETURN_CALL(erc), .PIO_LOCKED(plock), .REGION(region),
    .CACHEABLE(cach), .BCACHE_ALLOC(balloc), .ICACHE_FILL(ifill), .GFX_WRITE(gfx),
    .FETCH_REFUSED(frefd), .TO_MEM_CTRL(tomem), .TO_PERIPHERAL_IO(toio), .BUS_ADDR(rbus),
    .DMA_REFUSED(drefd), .RESV_VALID(rvalid), .RESV_ADDR(raddr));
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic put(input logic [33:0] a, input logic f, input logic w);
    @(posedge clk);
    addr <= a;
    fetch <= f;
    wr <= w;
    @(negedge clk);
  endtask
  task automatic dma(input logic [31:0] a);
    @(posedge clk);
    dreq <= 1'b1;
    daddr <= a;
    @(posedge clk);
    dreq <= 1'b0;
    @(negedge clk);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ll <= k == 0;
    sc <= k == 1;
    erc <= k == 2;
    @(posedge clk);
    {ll, sc, erc} <= 3'h0;
    @(negedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regions;
    logic [33:0] a;
    for (int i = 0; i < 22; i++) begin
      a = i[0] ? (i < 21 ? base[i/2+1] - 34'h1 : '1) : base[i/2];
      put(a, 1'b0, 1'b0);
      `CHK(region, region_pkg::region_e'(i/2))
      `CHK(cach, i < 2)
      `CHK({tomem, toio}, {i < 10, i >= 10})
      `CHK(rbus, i/2 == 9 ? a >> 5 : a)
    end
    $display("regions done");
  endtask
  task automatic t_fetch;
    for (int q = 0; q < 4; q++) begin
      put({q[1:0], 32'h0000_0100}, 1'b1, 1'b0);
      `CHK({frefd, ifill, balloc}, {q != 0, q == 0, 1'b0})
      `CHK({tomem, toio}, {q == 0, 1'b0})
    end
    put(34'h0_2000_0100, 1'b1, 1'b0);
    `CHK(ifill, 1'b1)
    put(34'h1_1fff_fff0, 1'b0, 1'b1);
    `CHK(gfx, 1'b1)
    put(34'h1_2000_0000, 1'b0, 1'b1);
    `CHK({gfx, balloc}, 2'h0)
    put(34'h0_0000_0040, 1'b0, 1'b0);
    `CHK(balloc, 1'b1)
    $display("fetch done");
  endtask
  task automatic t_dma;
    logic [31:0] d [3] = '{32'h1fff_ffe0, 32'h4000_0000, 32'hffff_ffff};
    for (int i = 0; i < 3; i++) begin
      dma(d[i]);
      `CHK(drefd, i > 0)
    end
    $display("dma done");
  endtask
  task automatic t_lock;
    put(34'h0_0000_1234, 1'b0, 1'b0);
    pulse(0);
    `CHK({rvalid, raddr}, {1'b1, 34'h0_0000_1220})
    dma(32'h0000_1240);
    @(negedge clk);
    `CHK(rvalid, 1'b1)
    dma(32'h0000_123c);
    @(negedge clk);
    `CHK(rvalid, 1'b0)
    for (int k = 1; k < 3; k++) begin
      pulse(0);
      `CHK(rvalid, 1'b1)
      pulse(k);
      `CHK(rvalid, 1'b0)
    end
    pulse(0);
    `CHK(rvalid, 1'b1)
    @(posedge clk);
    plock <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    `CHK(rvalid, 1'b0)
    pulse(0);
    `CHK(rvalid, 1'b0)
    $display("lock done");
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    base = '{34'h0, region_pkg::BASE_NONCACHE, region_pkg::BASE_NXM, region_pkg::BASE_GFX,
      region_pkg::BASE_MC_REG, region_pkg::BASE_PIO_REG, region_pkg::BASE_PCI_IACK,
      region_pkg::BASE_PCI_IO, region_pkg::BASE_PCI_CFG, region_pkg::BASE_PCI_SPARSE,
      region_pkg::BASE_PCI_DENSE};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK({rvalid, raddr}, 35'h0)
    t_regions;
    t_fetch;
    t_dma;
    t_lock;
    summarize;
  end
  // Tests need under a hundred cycles; this margin only cuts a hang
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    summarize;
  end
endmodule
`default_nettype wire
